// [verilog/xops_params.svh]
// Constants for the extended rotate, subtract and skip datapath.
`ifndef XOPS_PARAMS_SVH
`define XOPS_PARAMS_SVH

// Register port map, one byte per index.
`define XO_REG_WORKING  4'h0
`define XO_REG_STATUS   4'h1
`define XO_REG_RESULT   4'h2
`define XO_REG_SKIPS    4'h3
`define XO_REG_OPS      4'h4
`define XO_REG_ERROR    4'h5

// Widths of the data memory address and the register port address.
`define XO_ADDR_W       16
`define XO_REG_ADDR_W   4

// Status flag positions inside the status register.
`define XO_FLAG_C       0
`define XO_FLAG_AC      1
`define XO_FLAG_Z       2
`define XO_FLAG_OV      3
`define XO_FLAG_SC      4
`define XO_FLAG_CZ      5

// Reset and constant data values.
`define XO_WORKING_RST  8'h00
`define XO_STATUS_RST   6'h00
`define XO_COUNT_RST    8'h00
`define XO_FILL_VALUE   8'hff
`define XO_DEC_STEP     8'h01
`define XO_ERR_CLR_BIT  0

`endif

// [verilog/xops_pkg.sv]
// Types shared by the extended rotate, subtract and skip datapath.
package xops_pkg;

   // Operation codes issued by the sequencer.
   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_ROT_W     = 3'h1,
      OP_SBC_W     = 3'h2,
      OP_SBC_M     = 3'h3,
      OP_DSZ_M     = 3'h4,
      OP_DSZ_W     = 3'h5,
      OP_FILL      = 3'h6,
      OP_ILLEGAL   = 3'h7
   } op_e;

   // Status flags; c sits in bit 0 when packed into the status byte.
   typedef struct packed {
      logic cz;
      logic sc;
      logic ov;
      logic z;
      logic ac;
      logic c;
   } flags_s;

   // One operation with its operand byte already read from memory.
   typedef struct packed {
      op_e        op;
      logic [15:0] addr;
      logic [7:0] mem;
   } op_req_s;

   // What an operation does to the working register, memory and flags.
   typedef struct packed {
      logic [7:0] working;
      logic       working_we;
      logic [7:0] mem_wdata;
      logic       mem_we;
      flags_s     flags;
      logic       flags_we;
      logic       skip;
      logic       illegal;
      logic [7:0] result;
   } alu_res_s;

endpackage

// [verilog/xops_alu.sv]
// Combinational arithmetic for the extended operations.
`timescale 1ns/100ps
`include "xops_params.svh"

module xops_alu (
   input  wire xops_pkg::op_req_s  i_req,
   input  wire xops_pkg::flags_s   i_flags,
   input  wire logic [7:0]         i_working,
   output xops_pkg::alu_res_s      o_res
);

   // Zero test is shared by the subtract flags and the skip decision.
   function automatic logic is_null(input logic [7:0] v);
      is_null = (v == 8'h00);
   endfunction

   wire logic [7:0] mem_b    = i_req.mem;
   wire logic       borrow_i = ~i_flags.c;
   // Nine bits so the borrow out of bit 7 is visible.
   wire logic [8:0] diff_full = {1'b0, i_working} - {1'b0, mem_b}
                                - {8'h00, borrow_i};
   wire logic [4:0] diff_low  = {1'b0, i_working[3:0]}
                                - {1'b0, mem_b[3:0]} - {4'h0, borrow_i};
   wire logic [7:0] diff      = diff_full[7:0];
   wire logic [7:0] dec       = mem_b - `XO_DEC_STEP;
   wire logic [7:0] rot       = {i_flags.c, mem_b[7:1]};
   wire logic       ov_sub    = (i_working[7] ^ mem_b[7])
                                & (diff[7] ^ i_working[7]);

   // Flags after a subtract; chained zero keeps earlier zero in the chain.
   xops_pkg::flags_s sub_flags;
   always_comb begin
      sub_flags.c  = ~diff_full[8];
      sub_flags.ac = ~diff_low[4];
      sub_flags.z  = is_null(diff);
      sub_flags.ov = ov_sub;
      sub_flags.sc = ov_sub ^ diff[7];
      sub_flags.cz = i_flags.z & is_null(diff);
   end

   // Flags after a rotate: only carry moves.
   xops_pkg::flags_s rot_flags;
   always_comb begin
      rot_flags   = i_flags;
      rot_flags.c = mem_b[0];
   end

   // Per-operation effects; working, memory data and flags not named hold their old value, result reads zero.
   always_comb begin
      o_res            = '0;
      o_res.working    = i_working;
      o_res.mem_wdata  = mem_b;
      o_res.flags      = i_flags;
      case (i_req.op)
         xops_pkg::OP_ROT_W: begin
            o_res.working    = rot;
            o_res.working_we = 1'b1;
            o_res.flags      = rot_flags;
            o_res.flags_we   = 1'b1;
            o_res.result     = rot;
         end
         xops_pkg::OP_SBC_W: begin
            o_res.working    = diff;
            o_res.working_we = 1'b1;
            o_res.flags      = sub_flags;
            o_res.flags_we   = 1'b1;
            o_res.result     = diff;
         end
         xops_pkg::OP_SBC_M: begin
            o_res.mem_wdata  = diff;
            o_res.mem_we     = 1'b1;
            o_res.flags      = sub_flags;
            o_res.flags_we   = 1'b1;
            o_res.result     = diff;
         end
         xops_pkg::OP_DSZ_M: begin
            o_res.mem_wdata  = dec;
            o_res.mem_we     = 1'b1;
            o_res.skip       = is_null(dec);
            o_res.result     = dec;
         end
         xops_pkg::OP_DSZ_W: begin
            o_res.working    = dec;
            o_res.working_we = 1'b1;
            o_res.skip       = is_null(dec);
            o_res.result     = dec;
         end
         xops_pkg::OP_FILL: begin
            o_res.mem_wdata  = `XO_FILL_VALUE;
            o_res.mem_we     = 1'b1;
            o_res.result     = `XO_FILL_VALUE;
         end
         xops_pkg::OP_ILLEGAL: begin
            o_res.illegal    = 1'b1;
         end
         default: begin
            o_res.result     = 8'h00;
         end
      endcase
   end

endmodule

// [verilog/xops_core.sv]
// Extended-address rotate, subtract, decrement-skip and fill datapath.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`include "xops_params.svh"

module xops_core (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   input  wire logic                          i_op_valid,
   input  wire xops_pkg::op_req_s             i_op,
   output logic                               o_op_ready,
   output logic                               o_mem_we,
   output logic [`XO_ADDR_W-1:0]              o_mem_addr,
   output logic [7:0]                         o_mem_wdata,
   output logic                               o_skip,
   output logic                               o_dummy,
   output logic [7:0]                         o_working,
   output xops_pkg::flags_s                   o_flags,
   input  wire logic [`XO_REG_ADDR_W-1:0]     i_reg_addr,
   input  wire logic [7:0]                    i_reg_wdata,
   input  wire logic                          i_reg_wr,
   input  wire logic                          i_reg_rd,
   output logic [7:0]                         o_reg_rdata
);

   // Sequencer slot: normal issue, or the dummy slot after a skip.
   typedef enum logic [0:0] {
      ST_RUN   = 1'b0,
      ST_SKIP  = 1'b1
   } slot_e;

   slot_e                state_r;
   slot_e                state_nxt;
   logic [7:0]           working_r;
   logic [7:0]           working_nxt;
   xops_pkg::flags_s     flags_r;
   xops_pkg::flags_s     flags_nxt;
   logic                 mem_we_r;
   logic [`XO_ADDR_W-1:0] mem_addr_r;
   logic [7:0]           mem_wdata_r;
   logic                 skip_r;
   logic                 dummy_r;
   logic [7:0]           result_r;
   logic [7:0]           skip_cnt_r;
   logic [7:0]           op_cnt_r;
   logic                 err_r;
   logic                 err_nxt;
   logic [7:0]           rdata_r;
   xops_pkg::alu_res_s   alu_res;

   // The arithmetic itself lives in a purely combinational leaf.
   xops_alu u_alu (
      .i_req     (i_op),
      .i_flags   (flags_r),
      .i_working (working_r),
      .o_res     (alu_res)
   );

   // Issue handshake and register port decode.
   wire logic take         = i_op_valid && (state_r == ST_RUN);
   wire logic take_real    = take && (i_op.op != xops_pkg::OP_NONE);
   wire logic wr_working   = i_reg_wr && (i_reg_addr == `XO_REG_WORKING);
   wire logic wr_status    = i_reg_wr && (i_reg_addr == `XO_REG_STATUS);
   wire logic wr_error     = i_reg_wr && (i_reg_addr == `XO_REG_ERROR);
   wire logic err_clear    = wr_error && i_reg_wdata[`XO_ERR_CLR_BIT];
   wire logic op_working   = take && alu_res.working_we;
   wire logic op_flags     = take && alu_res.flags_we;
   wire logic skip_now     = take && alu_res.skip;

   // New ops are refused only while the dummy slot runs.
   assign o_op_ready = (state_r == ST_RUN);

   // A taken skip buys exactly one dummy slot before the next issue.
   always_comb begin
      case (state_r)
         ST_RUN: begin
            if (skip_now) begin
               state_nxt = ST_SKIP;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_SKIP: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // An executing operation beats a software write in the same cycle, so
   // the architectural result is never silently overwritten.
   always_comb begin
      if (op_working) begin
         working_nxt = alu_res.working;
      end else if (wr_working) begin
         working_nxt = i_reg_wdata;
      end else begin
         working_nxt = working_r;
      end
   end

   // Flags move only for ops that own them or a status write; skips and fill keep them.
   always_comb begin
      if (op_flags) begin
         flags_nxt = alu_res.flags;
      end else if (wr_status) begin
         flags_nxt = xops_pkg::flags_s'(i_reg_wdata[5:0]);
      end else begin
         flags_nxt = flags_r;
      end
   end

   // Illegal opcode flag: a new event wins over a clear in the same cycle.
   assign err_nxt = (take && alu_res.illegal) || (err_r && !err_clear);

   // Register read mux; unmapped indices read zero.
   wire logic [7:0] rd_mux =
      (i_reg_addr == `XO_REG_WORKING) ? working_r :
      (i_reg_addr == `XO_REG_STATUS)  ? {2'b00, flags_r} :
      (i_reg_addr == `XO_REG_RESULT)  ? result_r :
      (i_reg_addr == `XO_REG_SKIPS)   ? skip_cnt_r :
      (i_reg_addr == `XO_REG_OPS)     ? op_cnt_r :
      (i_reg_addr == `XO_REG_ERROR)   ? {7'h00, err_r} :
                                        8'h00;

   // Slot state machine.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Architectural working register and flags.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         working_r <= `XO_WORKING_RST;
         flags_r   <= xops_pkg::flags_s'(`XO_STATUS_RST);
      end else begin
         working_r <= working_nxt;
         flags_r   <= flags_nxt;
      end
   end

   // Memory write port: one-cycle strobe, data held until the next write.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mem_we_r    <= 1'b0;
         mem_addr_r  <= '0;
         mem_wdata_r <= 8'h00;
      end else begin
         mem_we_r <= take && alu_res.mem_we;
         if (take && alu_res.mem_we) begin
            mem_addr_r  <= i_op.addr;
            mem_wdata_r <= alu_res.mem_wdata;
         end
      end
   end

   // Skip pulse to the sequencer and the dummy slot marker, both in the same cycle.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         skip_r  <= 1'b0;
         dummy_r <= 1'b0;
      end else begin
         skip_r  <= skip_now;
         dummy_r <= skip_now;
      end
   end

   // Last result and activity counters; counters wrap silently.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         result_r   <= `XO_COUNT_RST;
         skip_cnt_r <= `XO_COUNT_RST;
         op_cnt_r   <= `XO_COUNT_RST;
      end else begin
         if (take_real) begin
            result_r <= alu_res.result;
            op_cnt_r <= op_cnt_r + 8'h01;
         end
         if (skip_now) begin
            skip_cnt_r <= skip_cnt_r + 8'h01;
         end
      end
   end

   // Sticky illegal-op flag and read data pipeline.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         err_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         err_r <= err_nxt;
         if (i_reg_rd) begin
            rdata_r <= rd_mux;
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   // Outputs come straight from flip-flops.
   assign o_mem_we    = mem_we_r;
   assign o_mem_addr  = mem_addr_r;
   assign o_mem_wdata = mem_wdata_r;
   assign o_skip      = skip_r;
   assign o_dummy     = dummy_r;
   assign o_working   = working_r;
   assign o_flags     = flags_r;
   assign o_reg_rdata = rdata_r;

endmodule

// [verification/xops_core_checker.sv]
// Assertion checker for the extended rotate, subtract and skip datapath.
`timescale 1ns/100ps
`include "xops_params.svh"

module xops_core_checker (
   input wire logic                      i_clk_sys,
   input wire logic                      i_rst,
   input wire logic                      i_op_valid,
   input wire xops_pkg::op_req_s         i_op,
   input wire logic                      o_op_ready,
   input wire logic                      o_mem_we,
   input wire logic [`XO_ADDR_W-1:0]     o_mem_addr,
   input wire logic [7:0]                o_mem_wdata,
   input wire logic                      o_skip,
   input wire logic                      o_dummy,
   input wire logic [7:0]                o_working,
   input wire xops_pkg::flags_s          o_flags,
   input wire logic [`XO_REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0]                i_reg_wdata,
   input wire logic                      i_reg_wr,
   input wire logic                      i_reg_rd,
   input wire logic [7:0]                o_reg_rdata
);
   // Which operation is taken at this edge, and the borrow arithmetic.
   wire       take   = i_op_valid && o_op_ready;
   wire       is_rot = take && (i_op.op == xops_pkg::OP_ROT_W);
   wire       is_sbw = take && (i_op.op == xops_pkg::OP_SBC_W);
   wire       is_sbm = take && (i_op.op == xops_pkg::OP_SBC_M);
   wire       is_dsm = take && (i_op.op == xops_pkg::OP_DSZ_M);
   wire       is_dsw = take && (i_op.op == xops_pkg::OP_DSZ_W);
   wire       is_fil = take && (i_op.op == xops_pkg::OP_FILL);
   wire [8:0] diff = {1'b0, o_working} - {1'b0, i_op.mem}
                     - {8'h00, ~o_flags.c};
   wire [4:0] half = {1'b0, o_working[3:0]} - {1'b0, i_op.mem[3:0]}
                     - {4'h0, ~o_flags.c};
   wire       ovx  = (o_working[7] ^ i_op.mem[7]) & (diff[7] ^ o_working[7]);

   // All checks run on the system clock and rest while reset is high.
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   property p_rot_bits;
      is_rot |=> o_working == {$past(o_flags.c), $past(i_op.mem[7:1])}
         && o_flags.c == $past(i_op.mem[0]);
   endproperty
   a_rot_bits: assert property (p_rot_bits) else $error("rotate bits");
   property p_rot_keep;
      is_rot |=> !o_mem_we && o_flags[5:1] == $past(o_flags[5:1]);
   endproperty
   a_rot_keep: assert property (p_rot_keep) else $error("rotate side");
   property p_sbw;
      is_sbw |=> o_working == $past(diff[7:0]);
   endproperty
   a_sbw: assert property (p_sbw) else $error("subtract to working");
   property p_sbm;
      is_sbm |=> o_mem_we && o_mem_wdata == $past(diff[7:0])
         && $stable(o_working);
   endproperty
   a_sbm: assert property (p_sbm) else $error("subtract to memory");
   property p_sb_carry;
      (is_sbw || is_sbm) |=> o_flags.c == !$past(diff[8]);
   endproperty
   a_sb_carry: assert property (p_sb_carry) else $error("borrow carry");
   property p_sb_flags;
      (is_sbw || is_sbm) |=> o_flags.z == ($past(diff[7:0]) == 8'h00)
         && o_flags.ac == !$past(half[4]) && o_flags.ov == $past(ovx)
         && o_flags.sc == $past(ovx ^ diff[7])
         && o_flags.cz == ($past(o_flags.z) && o_flags.z);
   endproperty
   a_sb_flags: assert property (p_sb_flags) else $error("subtract flags");
   property p_dsm;
      is_dsm |=> o_mem_we && o_mem_wdata == $past(i_op.mem) - 8'h01
         && o_skip == ($past(i_op.mem) == 8'h01);
   endproperty
   a_dsm: assert property (p_dsm) else $error("decrement memory");
   property p_skip_slot;
      o_skip |-> $past(is_dsm || is_dsw) && o_dummy && !o_op_ready
         ##1 o_op_ready && !o_mem_we;
   endproperty
   a_skip_slot: assert property (p_skip_slot) else $error("skip slot");
   property p_dsw;
      is_dsw |=> o_working == $past(i_op.mem) - 8'h01 && !o_mem_we
         && o_skip == ($past(i_op.mem) == 8'h01);
   endproperty
   a_dsw: assert property (p_dsw) else $error("decrement working");
   property p_fill;
      is_fil |=> o_mem_we && o_mem_wdata == 8'hff && $stable(o_flags);
   endproperty
   a_fill: assert property (p_fill) else $error("fill byte");
   property p_ds_flags;
      (is_dsm || is_dsw) |=> $stable(o_flags);
   endproperty
   a_ds_flags: assert property (p_ds_flags) else $error("skip flags");

   // Main scenarios that the bench is expected to reach.
   c_skip: cover property (o_skip);
   c_sbm: cover property (is_sbm ##1 o_mem_we);
   c_wrap: cover property (is_dsm && i_op.mem == 8'h00);
endmodule

bind xops_core xops_core_checker xops_core_checker_i (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_op_valid(i_op_valid),
   .i_op(i_op), .o_op_ready(o_op_ready), .o_mem_we(o_mem_we),
   .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_skip(o_skip),
   .o_dummy(o_dummy), .o_working(o_working), .o_flags(o_flags),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata)
);

// [verification/xops_core_tb.sv]
// Self-checking testbench for the extended rotate, subtract and skip block.
`timescale 1ns/100ps
`include "xops_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: %h vs %h", $time, a, e); end end

module xops_core_tb;
   logic             i_clk_sys, i_rst, i_op_valid, i_reg_wr, i_reg_rd;
   logic             o_op_ready, o_mem_we, o_skip, o_dummy, bad_op;
   logic [3:0]       i_reg_addr;
   logic [7:0]       i_reg_wdata, o_mem_wdata, o_working, o_reg_rdata;
   logic [7:0]       w, n_ops, n_skips, res_last;
   logic [15:0]      o_mem_addr;
   xops_pkg::op_req_s i_op;
   xops_pkg::flags_s o_flags, f;
   integer           seed, num_errors, n_compared;
   integer           cycles = 0;
   // Corner cases as {op code, operand}: zero result, borrow, skips, wrap.
   logic [10:0]      corner [11] = '{11'h280, 11'h301, 11'h201, 11'h401,
      11'h501, 11'h400, 11'h500, 11'h502, 11'h101, 11'h612, 11'h734};

   xops_core xops_core_i (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_op_valid(i_op_valid),
      .i_op(i_op), .o_op_ready(o_op_ready), .o_mem_we(o_mem_we),
      .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_skip(o_skip),
      .o_dummy(o_dummy), .o_working(o_working), .o_flags(o_flags),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

   // The clock runs at 10 MHz.
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   // A hang ends the run well after the roughly 500 cycles the test needs.
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   task automatic close_out;
      begin
         $display("errors %0d, compared %0d", num_errors, n_compared);
         if (num_errors == 0 && n_compared > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask

   // Register write; the model follows working and status writes.
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      begin
         i_reg_wr    <= 1'b1;
         i_reg_addr  <= a;
         i_reg_wdata <= d;
         if (a == `XO_REG_WORKING) w = d;
         if (a == `XO_REG_STATUS) f = d[5:0];
         @(posedge i_clk_sys);
         i_reg_wr    <= 1'b0;
      end
   endtask

   // Register read; data stand only in the cycle after the strobe.
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
      begin
         i_reg_rd   <= 1'b1;
         i_reg_addr <= a;
         @(posedge i_clk_sys);
         i_reg_rd   <= 1'b0;
         #1;
         `CHK(o_reg_rdata, e)
         @(posedge i_clk_sys);
      end
   endtask

   // Predicts one operation, issues it and compares working, flags, memory write and skip outputs.
   task automatic do_op(input logic [2:0] opc, input logic [7:0] m);
      logic [8:0]       d;
      logic [4:0]       h;
      logic [7:0]       ew, ewd;
      logic [15:0]      a;
      logic             ewe, esk, ov;
      xops_pkg::flags_s ef;
      begin
         d   = {1'b0, w} - {1'b0, m} - {8'h00, ~f.c};
         h   = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f.c};
         ov  = (w[7] ^ m[7]) & (d[7] ^ w[7]);
         a   = 16'($random(seed));
         ew  = w;
         ef  = f;
         ewe = opc == 3'h3 || opc == 3'h4 || opc == 3'h6;
         ewd = (opc == 3'h3) ? d[7:0] : (opc == 3'h4) ? m - 8'h01 : 8'hff;
         esk = (opc == 3'h4 || opc == 3'h5) && m == 8'h01;
         if (opc == 3'h1) ew = {f.c, m[7:1]};
         if (opc == 3'h1) ef.c = m[0];
         if (opc == 3'h2) ew = d[7:0];
         if (opc == 3'h5) ew = m - 8'h01;
         // The last-result register follows every op except none.
         if (opc == 3'h1 || opc == 3'h2 || opc == 3'h5) res_last = ew;
         if (opc == 3'h3 || opc == 3'h4 || opc == 3'h6) res_last = ewd;
         if (opc == 3'h7) res_last = 8'h00;
         if (opc == 3'h2 || opc == 3'h3)
            ef = {f.z & ~|d[7:0], ov ^ d[7], ov, ~|d[7:0], ~h[4], ~d[8]};
         n_ops   = n_ops + 8'(opc != 3'h0);
         n_skips = n_skips + 8'(esk);
         bad_op  = bad_op | (opc == 3'h7);
         i_op_valid <= 1'b1;
         i_op       <= '{xops_pkg::op_e'(opc), a, m};
         @(posedge i_clk_sys);
         i_op_valid <= esk;
         #1;
         `CHK(o_working, ew)
         `CHK(o_flags, ef)
         `CHK(o_mem_we, ewe)
         if (ewe) `CHK({o_mem_addr, o_mem_wdata}, {a, ewd})
         `CHK({o_skip, o_dummy, o_op_ready}, {esk, esk, ~esk})
         if (esk) begin
            @(posedge i_clk_sys);
            i_op_valid <= 1'b0;
            #1;
            `CHK({o_mem_we, o_skip, o_op_ready, o_working}, {3'h1, ew})
         end
         w = ew;
         f = ef;
         @(posedge i_clk_sys);
      end
   endtask

   // Main sequence: reset, corners, random traffic, then register readback.
   initial begin
      seed        = 32'h3841bf5f;
      num_errors  = 0;
      n_compared  = 0;
      i_rst       = 1'b1;
      i_op_valid  = 1'b0;
      i_op        = '0;
      i_reg_addr  = 4'h0;
      i_reg_wdata = 8'h00;
      i_reg_wr    = 1'b0;
      i_reg_rd    = 1'b0;
      {w, f, n_ops, n_skips, bad_op} = '0;
      res_last    = 8'h00;
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(posedge i_clk_sys);
      #1;
      `CHK({o_working, o_flags, o_op_ready}, {8'h00, 6'h00, 1'b1})
      @(posedge i_clk_sys);
      reg_wr(`XO_REG_STATUS, 8'h05);
      reg_wr(`XO_REG_WORKING, 8'h80);
      for (int i = 0; i < 11; i++) begin
         do_op(corner[i][10:8], corner[i][7:0]);
      end
      for (int i = 0; i < 200; i++) begin
         if (i % 10 == 0) reg_wr(`XO_REG_STATUS, 8'($random(seed)));
         if (i % 10 == 5) reg_wr(`XO_REG_WORKING, 8'($random(seed)));
         do_op(3'($random(seed)), (i % 3 == 0) ? 8'h01 : 8'($random(seed)));
      end
      reg_rd(`XO_REG_WORKING, w);
      reg_rd(`XO_REG_STATUS, {2'b00, f});
      reg_rd(`XO_REG_OPS, n_ops);
      reg_rd(`XO_REG_RESULT, res_last);
      reg_rd(`XO_REG_SKIPS, n_skips);
      reg_rd(`XO_REG_ERROR, {7'h00, bad_op});
      reg_wr(`XO_REG_ERROR, 8'h01);
      reg_rd(`XO_REG_ERROR, 8'h00);
      reg_rd(4'hf, 8'h00);
      close_out();
   end
endmodule
